// ===== core/ssr_receiver.sv
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps

// What this block does
// - Clock-source bit clear selects slave operation
// - Sync plus port enable, source clear: slave receive
// - Single receive enable ignored in slave mode
// - Continuous enable keeps receiving through core sleep
// - Full word moves to buffer unless it overruns, sets flag
// - Masked-in flag raises interrupt, wakes core
// - Global enable: wake branches to vector 0020h
// - Nine-bit select gives nine-bit words
// - Ninth bit and errors in receive status
// - Low eight data bits in receive buffer
// - Clearing continuous enable clears pending error
// - Clearing enables aborts and idles receive logic
module ssr_receiver (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // Register port
    input wire logic [2:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // Serial link pins
    input wire logic shift_clk_i,
    input wire logic serial_data_i,
    // Core sleep state
    input wire logic core_sleep_i,
    // Interrupt and wake
    output logic irq_o,
    output logic wake_o,
    output logic branch_o,
    output logic [15:0] vector_o
);

    // ****************************************
    // Declarations
    // ****************************************
    logic [7:0] transmit_status_register;
    logic [7:0] receive_status_register;
    logic [7:0] receive_buffer_register;
    logic [7:0] core_ctrl;
    logic [1:0] int_status;
    logic [1:0] int_mask;
    logic [7:0] next_rdata;
    logic ninth_data;
    logic overrun;
    logic clk_prev;
    logic clk_rise;
    logic link_clk;
    logic link_data;
    logic [1:0] link_sync;
    ssr_pkg::ssr_rx_state_e state;
    ssr_pkg::ssr_rx_state_e next_state;
    logic word_done;
    logic [8:0] word;
    logic overrun_event;
    logic [1:0] int_set;
    logic [1:0] int_clear;
    logic [1:0] next_int_status;
    logic next_wake;
    logic next_branch;
    logic [15:0] next_vector;
    logic [7:0] rx_status_view;
    logic [7:0] core_ctrl_view;
    logic core_busy;
    logic shift_clear;
    logic shift_enable;

    // ****************************************
    // Configuration fields
    // ****************************************
    logic clock_source_select;
    logic sync_select;
    logic serial_port_enable;
    logic nine_bit_receive_select;
    logic continuous_receive_enable;
    logic global_int_enable;
    logic slave_mode;
    logic rx_enable;

    assign clock_source_select = transmit_status_register[ssr_pkg::TX_CLOCK_SOURCE_BIT];
    assign sync_select = transmit_status_register[ssr_pkg::TX_SYNC_SELECT_BIT];
    assign serial_port_enable = receive_status_register[ssr_pkg::RX_PORT_ENABLE_BIT];
    assign nine_bit_receive_select = receive_status_register[ssr_pkg::RX_NINE_BIT_BIT];
    assign continuous_receive_enable = receive_status_register[ssr_pkg::RX_CONT_ENABLE_BIT];
    assign global_int_enable = core_ctrl[ssr_pkg::CORE_GLOBAL_EN_BIT];

    // Slave receive needs sync, port enable and external clock
    assign slave_mode = sync_select && serial_port_enable && !clock_source_select;
    // Single receive enable has no say in slave mode
    assign rx_enable = slave_mode && continuous_receive_enable;

    // ****************************************
    // Register write and read decode
    // ****************************************
    logic wr_tx_status;
    logic wr_rx_status;
    logic wr_int_status;
    logic wr_int_mask;
    logic wr_core_ctrl;
    logic rd_tx_status;
    logic rd_rx_status;
    logic rd_rx_buffer;
    logic rd_int_status;
    logic rd_int_mask;
    logic rd_core_ctrl;

    assign wr_tx_status = reg_wr_i && (reg_addr_i == ssr_pkg::ADDR_TX_STATUS);
    assign wr_rx_status = reg_wr_i && (reg_addr_i == ssr_pkg::ADDR_RX_STATUS);
    assign wr_int_status = reg_wr_i && (reg_addr_i == ssr_pkg::ADDR_INT_STATUS);
    assign wr_int_mask = reg_wr_i && (reg_addr_i == ssr_pkg::ADDR_INT_MASK);
    assign wr_core_ctrl = reg_wr_i && (reg_addr_i == ssr_pkg::ADDR_CORE_CTRL);
    assign rd_tx_status = reg_rd_i && (reg_addr_i == ssr_pkg::ADDR_TX_STATUS);
    assign rd_rx_status = reg_rd_i && (reg_addr_i == ssr_pkg::ADDR_RX_STATUS);
    assign rd_rx_buffer = reg_rd_i && (reg_addr_i == ssr_pkg::ADDR_RX_BUFFER);
    assign rd_int_status = reg_rd_i && (reg_addr_i == ssr_pkg::ADDR_INT_STATUS);
    assign rd_int_mask = reg_rd_i && (reg_addr_i == ssr_pkg::ADDR_INT_MASK);
    assign rd_core_ctrl = reg_rd_i && (reg_addr_i == ssr_pkg::ADDR_CORE_CTRL);

    // ****************************************
    // Configuration registers
    // ****************************************
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            transmit_status_register <= ssr_pkg::TX_STATUS_RST;
        end else if (wr_tx_status) begin
            transmit_status_register <= reg_wdata_i;
        end
    end

    // Low four bits are status, not storage
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            receive_status_register <= ssr_pkg::RX_STATUS_RST;
        end else if (wr_rx_status) begin
            receive_status_register <= {reg_wdata_i[7:4], 4'h0};
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            int_mask <= ssr_pkg::INT_MASK_RST;
        end else if (wr_int_mask) begin
            int_mask <= reg_wdata_i[1:0];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            core_ctrl <= ssr_pkg::CORE_CTRL_RST;
        end else if (wr_core_ctrl) begin
            core_ctrl <= reg_wdata_i;
        end
    end

    // ****************************************
    // Link pin synchronisers
    // ****************************************
    ssr_sync #(
        .WIDTH(2)
    ) u_link_sync (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .async_i({serial_data_i, shift_clk_i}),
        .sync_o(link_sync)
    );

    assign link_clk = link_sync[0];
    assign link_data = link_sync[1];

    // ****************************************
    // Shift clock edge detect
    // ****************************************
    // Resets to the idle low level so no false edge follows reset
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            clk_prev <= 1'b0;
        end else begin
            clk_prev <= link_clk;
        end
    end

    assign clk_rise = link_clk && !clk_prev;

    // ****************************************
    // Receive state machine
    // ****************************************
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            state <= ssr_pkg::SSR_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_comb begin
        next_state = state;
        unique case (state)
            ssr_pkg::SSR_IDLE: begin
                if (rx_enable) begin
                    next_state = ssr_pkg::SSR_RECEIVE;
                end
            end
            ssr_pkg::SSR_RECEIVE: begin
                if (!rx_enable) begin
                    next_state = ssr_pkg::SSR_IDLE;
                end else if (overrun_event) begin
                    next_state = ssr_pkg::SSR_HALTED;
                end
            end
            // Overrun holds off reception until the enable is cleared
            ssr_pkg::SSR_HALTED: begin
                if (!rx_enable) begin
                    next_state = ssr_pkg::SSR_IDLE;
                end
            end
            default: begin
                next_state = ssr_pkg::SSR_IDLE;
            end
        endcase
    end

    // Shifter runs only while receiving
    assign shift_clear = (state != ssr_pkg::SSR_RECEIVE);
    assign shift_enable = clk_rise && (state == ssr_pkg::SSR_RECEIVE);
    assign core_busy = (state == ssr_pkg::SSR_RECEIVE);

    // ****************************************
    // Receive shift register
    // ****************************************
    ssr_shifter u_shifter (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .clear_i(shift_clear),
        .shift_i(shift_enable),
        .bit_i(link_data),
        .nine_i(nine_bit_receive_select),
        .done_o(word_done),
        .word_o(word)
    );

    // ****************************************
    // Receive buffer and ninth bit
    // ****************************************
    // A word that overruns is dropped, the unread one kept
    assign overrun_event = word_done && int_status[ssr_pkg::INT_RECEIVE_BIT];

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            receive_buffer_register <= ssr_pkg::RX_BUFFER_RST;
            ninth_data <= 1'b0;
        end else if (word_done && !overrun_event) begin
            receive_buffer_register <= word[7:0];
            ninth_data <= word[8];
        end
    end

    // ****************************************
    // Overrun error
    // ****************************************
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            overrun <= 1'b0;
        end else if (overrun_event) begin
            overrun <= 1'b1;
        end else if (!continuous_receive_enable) begin
            overrun <= 1'b0;
        end
    end

    // ****************************************
    // Interrupt status, write one to clear
    // ****************************************
    assign int_set[ssr_pkg::INT_RECEIVE_BIT] = word_done;
    assign int_set[ssr_pkg::INT_OVERRUN_BIT] = overrun_event;
    assign int_clear = wr_int_status ? reg_wdata_i[1:0] : 2'h0;
    // A new event wins over a clear in the same cycle
    assign next_int_status = (int_status & ~int_clear) | int_set;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            int_status <= ssr_pkg::INT_STATUS_RST;
        end else begin
            int_status <= next_int_status;
        end
    end

    assign irq_o = |(int_status & int_mask);

    // ****************************************
    // Wake and branch towards the core
    // ****************************************
    assign next_wake = irq_o && core_sleep_i;
    assign next_branch = next_wake && global_int_enable;
    assign next_vector = next_branch ? ssr_pkg::IRQ_VECTOR : 16'h0000;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            wake_o <= 1'b0;
            branch_o <= 1'b0;
            vector_o <= 16'h0000;
        end else begin
            wake_o <= next_wake;
            branch_o <= next_branch;
            vector_o <= next_vector;
        end
    end

    // ****************************************
    // Register read back
    // ****************************************
    always_comb begin
        rx_status_view = receive_status_register;
        rx_status_view[ssr_pkg::RX_OVERRUN_BIT] = overrun;
        rx_status_view[ssr_pkg::RX_NINTH_DATA_BIT] = ninth_data;
    end

    always_comb begin
        core_ctrl_view = core_ctrl;
        core_ctrl_view[ssr_pkg::CORE_BUSY_BIT] = core_busy;
    end

    assign next_rdata = rd_tx_status ? transmit_status_register :
                        rd_rx_status ? rx_status_view :
                        rd_rx_buffer ? receive_buffer_register :
                        rd_int_status ? {6'h00, int_status} :
                        rd_int_mask ? {6'h00, int_mask} :
                        rd_core_ctrl ? core_ctrl_view :
                        8'h00;

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            reg_rdata_o <= next_rdata;
        end
    end

endmodule

// ===== core/ssr_shifter.sv
`timescale 1ns/1ps

module ssr_shifter (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // Control
    input wire logic clear_i,
    input wire logic shift_i,
    input wire logic bit_i,
    input wire logic nine_i,
    // Completed word
    output logic done_o,
    output logic [8:0] word_o
);

    logic [8:0] shift_reg;
    logic [3:0] count;
    logic [8:0] next_shift;
    logic [3:0] word_len;
    logic last_bit;

    // ****************************************
    // Bit assembly, first bit is the LSB
    // ****************************************
    assign next_shift = {bit_i, shift_reg[8:1]};
    assign word_len = nine_i ? ssr_pkg::WORD_LEN_9 : ssr_pkg::WORD_LEN_8;
    assign last_bit = shift_i && (count == word_len - 4'h1);

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || clear_i) begin
            shift_reg <= 9'h000;
            count <= 4'h0;
        end else if (last_bit) begin
            shift_reg <= 9'h000;
            count <= 4'h0;
        end else if (shift_i) begin
            shift_reg <= next_shift;
            count <= count + 4'h1;
        end
    end

    // Right align an 8-bit word
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || clear_i) begin
            done_o <= 1'b0;
            word_o <= 9'h000;
        end else begin
            done_o <= last_bit;
            if (last_bit) begin
                word_o <= nine_i ? next_shift : {1'b0, next_shift[8:1]};
            end
        end
    end

endmodule

// ===== core/ssr_sync.sv
`timescale 1ns/1ps

module ssr_sync #(
    parameter int WIDTH = 2
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // Asynchronous levels in, synchronised levels out
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    // ****************************************
    // Two flip-flops per bit
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            logic stage1;
            logic stage2;
            always_ff @(posedge mclk_i) begin
                if (sys_rst_i) begin
                    stage1 <= 1'b0;
                    stage2 <= 1'b0;
                end else begin
                    stage1 <= async_i[gi];
                    stage2 <= stage1;
                end
            end
            assign sync_o[gi] = stage2;
        end
    endgenerate

endmodule

// ===== pkg/ssr_pkg.sv
package ssr_pkg;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [2:0] ADDR_TX_STATUS = 3'h0;
    localparam logic [2:0] ADDR_RX_STATUS = 3'h1;
    localparam logic [2:0] ADDR_RX_BUFFER = 3'h2;
    localparam logic [2:0] ADDR_INT_STATUS = 3'h3;
    localparam logic [2:0] ADDR_INT_MASK = 3'h4;
    localparam logic [2:0] ADDR_CORE_CTRL = 3'h5;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int TX_CLOCK_SOURCE_BIT = 7;
    localparam int TX_SYNC_SELECT_BIT = 4;
    localparam int RX_PORT_ENABLE_BIT = 7;
    localparam int RX_NINE_BIT_BIT = 6;
    localparam int RX_SINGLE_ENABLE_BIT = 5;
    localparam int RX_CONT_ENABLE_BIT = 4;
    localparam int RX_OVERRUN_BIT = 1;
    localparam int RX_NINTH_DATA_BIT = 0;
    localparam int INT_RECEIVE_BIT = 0;
    localparam int INT_OVERRUN_BIT = 1;
    localparam int CORE_GLOBAL_EN_BIT = 0;
    localparam int CORE_BUSY_BIT = 1;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] TX_STATUS_RST = 8'h00;
    localparam logic [7:0] RX_STATUS_RST = 8'h00;
    localparam logic [7:0] RX_BUFFER_RST = 8'h00;
    localparam logic [1:0] INT_STATUS_RST = 2'h0;
    localparam logic [1:0] INT_MASK_RST = 2'h0;
    localparam logic [7:0] CORE_CTRL_RST = 8'h00;

    // ****************************************
    // Word lengths and interrupt vector
    // ****************************************
    localparam logic [3:0] WORD_LEN_8 = 4'h8;
    localparam logic [3:0] WORD_LEN_9 = 4'h9;
    localparam logic [15:0] IRQ_VECTOR = 16'h0020;

    // ****************************************
    // Receive states
    // ****************************************
    typedef enum logic [1:0] {
        SSR_IDLE,
        SSR_RECEIVE,
        SSR_HALTED
    } ssr_rx_state_e;

endpackage

// ===== verif/ssr_master_model.sv
`timescale 1ns/1ps
module ssr_master_model (
    output logic shift_clk_o,
    output logic data_o
);
    initial begin
        shift_clk_o = 1'b0;
        data_o = 1'b0;
    end
    // Clock runs only inside a word, data inverted after it
    task automatic send(input logic [8:0] w, input int n);
        for (int i = 0; i < n; i++) begin
            data_o = w[i];
            #200 shift_clk_o = 1'b1;
            #200 shift_clk_o = 1'b0;
        end
        data_o = ~data_o;
    endtask
endmodule

// ===== verif/ssr_receiver_properties.sv
`timescale 1ns/1ps
module ssr_receiver_chk (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic [2:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic core_sleep_i,
    input wire logic irq_o,
    input wire logic wake_o,
    input wire logic branch_o,
    input wire logic [15:0] vector_o
);
    AST_VECTOR: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        branch_o |-> vector_o == 16'h0020) else $error("bad vector");
    AST_WAKE: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        wake_o |-> irq_o || $past(irq_o)) else $error("wake without irq");
    AST_IRQ_RST: assert property (@(posedge mclk_i)
        $fell(sys_rst_i) |-> !irq_o) else $error("irq after reset");
    sequence s_sleep_irq;
        irq_o && core_sleep_i;
    endsequence
    AST_WAKE_SLEEP: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        s_sleep_irq |=> wake_o) else $error("no wake in sleep");
    AST_BRANCH: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        branch_o |-> wake_o) else $error("branch without wake");
    AST_RDATA_IDLE: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        !$past(reg_rd_i) |-> reg_rdata_o == 8'h00) else $error("read data without read");
    AST_IRQ_HOLD: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        irq_o && !(reg_wr_i && (reg_addr_i == 3'h3 || reg_addr_i == 3'h4)) |=> irq_o)
        else $error("irq dropped without clear");
endmodule
bind ssr_receiver ssr_receiver_chk u_chk (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .core_sleep_i(core_sleep_i),
    .irq_o(irq_o), .wake_o(wake_o), .branch_o(branch_o), .vector_o(vector_o));

// ===== verif/tb.sv
`timescale 1ns/1ps
module tb;
    logic mclk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [2:0] reg_addr_i = 3'h0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic core_sleep_i = 1'b0;
    logic [7:0] reg_rdata_o, d, cfg;
    logic shift_clk_i, serial_data_i, irq_o, wake_o, branch_o;
    logic [15:0] vector_o;
    logic [8:0] w;
    int failures = 0;
    int num_checks = 0;
    int seed = 32'h67c0;
    int cyc = 0;
    always #25 mclk_i = ~mclk_i;
    ssr_receiver u_dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .shift_clk_i(shift_clk_i), .serial_data_i(serial_data_i),
        .core_sleep_i(core_sleep_i), .irq_o(irq_o), .wake_o(wake_o), .branch_o(branch_o),
        .vector_o(vector_o));
    ssr_master_model u_mst (.shift_clk_o(shift_clk_i), .data_o(serial_data_i));
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge mclk_i);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_wr_i <= 1'b1;
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge mclk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge mclk_i);
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask
    task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic chk_vec(input string n, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            failures++;
            print_verdict();
        end
    end
    initial begin
        repeat (2) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        rd(3'h3);
        chk("int status", 9'h000, {1'b0, d});
        wr(3'h0, 8'h10);
        wr(3'h4, 8'h01);
        wr(3'h5, 8'h01);
        for (int t = 0; t < 6; t++) begin
            w = 9'($random(seed));
            cfg = {1'b1, t[0], w[3], 5'h10};
            wr(3'h1, cfg);
            if (t == 2) begin
                u_mst.send(w, 4);
                wr(3'h1, 8'h80);
                wr(3'h1, cfg);
            end
            core_sleep_i <= t[1];
            u_mst.send(w, t[0] ? 9 : 8);
            for (int k = 0; k < 40 && irq_o !== 1'b1; k++) begin
                @(posedge mclk_i);
                #1;
            end
            chk("irq", 9'h001, {8'h00, irq_o});
            @(posedge mclk_i);
            #1 chk("wake", {8'h00, t[1]}, {8'h00, wake_o});
            chk("branch", {8'h00, t[1]}, {8'h00, branch_o});
            chk_vec("vector", t[1] ? 16'h0020 : 16'h0000, vector_o);
            rd(3'h1);
            if (t[0]) chk("ninth", {8'h00, w[8]}, {8'h00, d[0]});
            rd(3'h2);
            chk("data", {1'b0, w[7:0]}, {1'b0, d});
            wr(3'h3, 8'h01);
            @(posedge mclk_i);
            #1 chk("irq clear", 9'h000, {8'h00, irq_o});
            $display("word %0d done", t);
        end
        wr(3'h1, 8'h90);
        u_mst.send(9'h0a5, 8);
        u_mst.send(9'h03c, 8);
        repeat (10) @(posedge mclk_i);
        rd(3'h1);
        chk("overrun", 9'h002, {7'h00, d[1:0]});
        rd(3'h2);
        chk("kept data", 9'h0a5, {1'b0, d});
        rd(3'h3);
        chk("int status both", 9'h003, {1'b0, d});
        wr(3'h1, 8'h80);
        rd(3'h1);
        chk("overrun clear", 9'h000, {8'h00, d[1]});
        wr(3'h3, 8'h03);
        wr(3'h0, 8'h90);
        wr(3'h1, 8'h90);
        u_mst.send(9'($random(seed)), 8);
        repeat (20) @(posedge mclk_i);
        #1 chk("master mode irq", 9'h000, {8'h00, irq_o});
        $display("overrun and master mode done");
        print_verdict();
    end
endmodule
